// File: rtl/ata_cmd_pkg.sv
// Constants and types for the task-file command engine
package ata_cmd_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_FEAT = 8'h00;
  localparam logic [7:0] OFF_SCNT = 8'h04;
  localparam logic [7:0] OFF_LBAL = 8'h08;
  localparam logic [7:0] OFF_LBAM = 8'h0c;
  localparam logic [7:0] OFF_LBAH = 8'h10;
  localparam logic [7:0] OFF_DEVH = 8'h14;
  localparam logic [7:0] OFF_CMD  = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1c;
  localparam logic [7:0] OFF_ERR  = 8'h20;
  localparam logic [7:0] OFF_DATA = 8'h24;
  localparam logic [7:0] OFF_CTRL = 8'h28;
  // Field positions
  localparam int unsigned DEVH_DRV_BIT = 4;
  localparam int unsigned CTRL_SMART_BIT = 0;
  localparam int unsigned CTRL_DEVID_BIT = 1;
  localparam int unsigned STAT_BSY_BIT = 7;
  localparam int unsigned STAT_RDY_BIT = 6;
  localparam int unsigned STAT_STBY_BIT = 5;
  localparam int unsigned STAT_DRQ_BIT = 3;
  localparam int unsigned STAT_ERR_BIT = 0;
  localparam int unsigned ERR_ABRT_BIT = 2;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] TF_RST = 8'h00;
  // Opcodes and SMART keys
  localparam logic [7:0] OPC_SMART = 8'hb0;
  localparam logic [7:0] SUB_SAVE = 8'hd3;
  localparam logic [7:0] SUB_WLOG = 8'hd6;
  localparam logic [7:0] SMART_MID = 8'h4f;
  localparam logic [7:0] SMART_HIGH = 8'hc2;
  localparam logic [7:0] OPC_STBY_A = 8'h96;
  localparam logic [7:0] OPC_STBY_B = 8'he2;
  localparam logic [7:0] OPC_STBYI_A = 8'h94;
  localparam logic [7:0] OPC_STBYI_B = 8'he0;
  localparam logic [7:0] OPC_WBUF = 8'he8;
  localparam logic [7:0] OPC_RBUF = 8'he4;
  // Writable host log window
  localparam logic [7:0] LOG_WR_LO = 8'h80;
  localparam logic [7:0] LOG_WR_HI = 8'h9f;
  // Sector geometry: 512 bytes as 256 words
  localparam logic [7:0] LAST_WORD = 8'hff;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SAVE_TIME_NS = 2000;
  localparam int unsigned STORE_TIME_NS = 1000;
  localparam int unsigned SPIN_TIME_NS = 5000;
  localparam logic [15:0] SAVE_CYC = 16'((SAVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] STORE_CYC = 16'((STORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] SPIN_CYC = 16'((SPIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {ST_IDLE, ST_BUSY, ST_DRQ_IN, ST_DRQ_OUT, ST_STORE, ST_SPIN} state_type;
  typedef enum logic [2:0] {OP_SAVE, OP_LOG, OP_WBUF, OP_RBUF, OP_STBY, OP_STBYI, OP_AUTO} op_type;
endpackage

// File: rtl/ata_cmd_engine.sv
// Task-file command engine: SMART save and log write, standby, buffer commands
// How it works
// - Attribute save stores attributes to non-volatile memory at once, regardless of any auto-save timer.
// - Attribute save holds BSY while writing, then drops BSY and raises INTRQ.
// - SMART commands abort when SMART is off or Features, LBA Mid or LBA High are invalid.
// - The host gives the sector count and the device takes that many 512-byte sectors into the log.
// - The target log address of a log write comes from LBA Low.
// - A log write to a read-only log address is aborted.
// - Opcodes 96h and E2h are Standby and put the device in Standby mode.
// - Standby loads the standby timer from Sector Count.
// - After power-on the standby timer is disabled until programmed.
// - Opcodes 94h and E0h are Standby Immediate, spinning down into Standby mode.
// - Standby Immediate raises its interrupt before the Standby transition has finished.
// - Write Buffer E8h takes exactly 512 bytes into the sector buffer.
// - Read Buffer right after Write Buffer returns the same 512 bytes.
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module ata_cmd_engine import ata_cmd_pkg::*; #(
  parameter int unsigned STANDBY_UNIT_CYC = 500000000
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             intrq,
  output logic             nvm_req,
  output logic             nvm_is_log,
  output logic      [7:0]  nvm_log_addr,
  output logic             spin_down,
  output logic             standby
);
  state_type   state_q;
  op_type      op_q;
  logic [7:0]  feat_q, scnt_q, lbal_q, lbam_q, lbah_q, devh_q, ctrl_q, err_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [15:0] cnt_q;
  logic [7:0]  ptr_q, sect_q, tmr_val_q;
  logic [31:0] unit_q;
  logic [7:0]  units_q;
  logic [15:0] buf_mem [256];
  logic        rd_take, stat_rd, data_rd, data_wr, cmd_wr, abort_d, done_d, tmr_fire;

  function automatic logic smart_keys_ok(input logic [7:0] mid, input logic [7:0] high);
    return (mid == SMART_MID) && (high == SMART_HIGH);
  endfunction

  function automatic logic log_writable(input logic [7:0] addr);
    return (addr >= LOG_WR_LO) && (addr <= LOG_WR_HI);
  endfunction

  // Bus decode
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign stat_rd = rd_take && (haddr[7:0] == OFF_STAT);
  assign data_rd = rd_take && (haddr[7:0] == OFF_DATA) && (state_q == ST_DRQ_OUT);
  assign data_wr = wr_pend_q && (wr_addr_q == OFF_DATA) && (state_q == ST_DRQ_IN);
  assign cmd_wr = wr_pend_q && (wr_addr_q == OFF_CMD) && (state_q == ST_IDLE)
                  && (devh_q[DEVH_DRV_BIT] == ctrl_q[CTRL_DEVID_BIT]);
  assign tmr_fire = (tmr_val_q != 8'h00) && (units_q == tmr_val_q) && (state_q == ST_IDLE) && !standby;

  always_comb begin
    abort_d = 1'b0;
    if (hwdata[7:0] == OPC_SMART) begin
      abort_d = !ctrl_q[CTRL_SMART_BIT] || !smart_keys_ok(lbam_q, lbah_q)
                || ((feat_q != SUB_SAVE) && (feat_q != SUB_WLOG));
      if ((feat_q == SUB_WLOG) && !log_writable(lbal_q)) begin
        abort_d = 1'b1;
      end
    end else if (!(hwdata[7:0] inside {OPC_STBY_A, OPC_STBY_B, OPC_STBYI_A, OPC_STBYI_B, OPC_WBUF, OPC_RBUF})) begin
      abort_d = 1'b1;
    end
  end

  always_comb begin
    done_d = 1'b0;
    if (cmd_wr && (abort_d || hwdata[7:0] == OPC_STBYI_A || hwdata[7:0] == OPC_STBYI_B)) begin
      done_d = 1'b1;
    end else if (state_q == ST_BUSY && cnt_q == 16'h0001) begin
      done_d = 1'b1;
    end else if (data_wr && ptr_q == LAST_WORD && op_q != OP_LOG) begin
      done_d = 1'b1;
    end else if (state_q == ST_STORE && cnt_q == 16'h0001 && sect_q == 8'h01) begin
      done_d = 1'b1;
    end else if (data_rd && ptr_q == LAST_WORD) begin
      done_d = 1'b1;
    end else if (state_q == ST_SPIN && cnt_q == 16'h0001 && op_q == OP_STBY) begin
      done_d = 1'b1;
    end
  end

  // Bus address phase and fixed answers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      wr_pend_q <= hsel && hready && htrans[1] && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // Task file and control writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      feat_q <= TF_RST;
      scnt_q <= TF_RST;
      lbal_q <= TF_RST;
      lbam_q <= TF_RST;
      lbah_q <= TF_RST;
      devh_q <= TF_RST;
      ctrl_q <= CTRL_RST;
    end else if (ce && wr_pend_q && state_q == ST_IDLE) begin
      if (wr_addr_q == OFF_FEAT) begin
        feat_q <= hwdata[7:0];
      end else if (wr_addr_q == OFF_SCNT) begin
        scnt_q <= hwdata[7:0];
      end else if (wr_addr_q == OFF_LBAL) begin
        lbal_q <= hwdata[7:0];
      end else if (wr_addr_q == OFF_LBAM) begin
        lbam_q <= hwdata[7:0];
      end else if (wr_addr_q == OFF_LBAH) begin
        lbah_q <= hwdata[7:0];
      end else if (wr_addr_q == OFF_DEVH) begin
        devh_q <= hwdata[7:0];
      end else if (wr_addr_q == OFF_CTRL) begin
        ctrl_q <= hwdata[7:0];
      end
    end
  end

  // Command sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q      <= ST_IDLE;
      op_q         <= OP_SAVE;
      cnt_q        <= 16'h0000;
      ptr_q        <= 8'h00;
      sect_q       <= 8'h00;
      err_q        <= 8'h00;
      nvm_req      <= 1'b0;
      nvm_is_log   <= 1'b0;
      nvm_log_addr <= 8'h00;
      spin_down    <= 1'b0;
      standby      <= 1'b0;
    end else if (ce) begin
      nvm_req <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cmd_wr) begin
            err_q <= {5'h00, abort_d, 2'h0};
            ptr_q <= 8'h00;
            if (!abort_d) begin
              spin_down <= 1'b0;
              standby   <= 1'b0;
              if (hwdata[7:0] == OPC_SMART && feat_q == SUB_SAVE) begin
                op_q    <= OP_SAVE;
                state_q <= ST_BUSY;
                cnt_q   <= SAVE_CYC;
              end else if (hwdata[7:0] == OPC_SMART) begin
                op_q         <= OP_LOG;
                state_q      <= ST_DRQ_IN;
                sect_q       <= scnt_q;
                nvm_log_addr <= lbal_q;
              end else if (hwdata[7:0] == OPC_STBY_A || hwdata[7:0] == OPC_STBY_B) begin
                op_q      <= OP_STBY;
                state_q   <= ST_SPIN;
                cnt_q     <= SPIN_CYC;
                spin_down <= 1'b1;
              end else if (hwdata[7:0] == OPC_STBYI_A || hwdata[7:0] == OPC_STBYI_B) begin
                op_q      <= OP_STBYI;
                state_q   <= ST_SPIN;
                cnt_q     <= SPIN_CYC;
                spin_down <= 1'b1;
              end else if (hwdata[7:0] == OPC_WBUF) begin
                op_q    <= OP_WBUF;
                state_q <= ST_DRQ_IN;
              end else begin
                op_q    <= OP_RBUF;
                state_q <= ST_DRQ_OUT;
              end
            end
          end else if (tmr_fire) begin
            op_q      <= OP_AUTO;
            state_q   <= ST_SPIN;
            cnt_q     <= SPIN_CYC;
            spin_down <= 1'b1;
          end
        end
        ST_BUSY: begin
          cnt_q <= cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) begin
            nvm_req    <= 1'b1;
            nvm_is_log <= 1'b0;
            state_q    <= ST_IDLE;
          end
        end
        ST_DRQ_IN: begin
          if (data_wr) begin
            ptr_q <= ptr_q + 8'h01;
            if (ptr_q == LAST_WORD) begin
              state_q <= (op_q == OP_LOG) ? ST_STORE : ST_IDLE;
              cnt_q   <= STORE_CYC;
            end
          end
        end
        ST_STORE: begin
          cnt_q <= cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) begin
            nvm_req      <= 1'b1;
            nvm_is_log   <= 1'b1;
            nvm_log_addr <= lbal_q;
            sect_q       <= sect_q - 8'h01;
            state_q      <= (sect_q == 8'h01) ? ST_IDLE : ST_DRQ_IN;
          end
        end
        ST_DRQ_OUT: begin
          if (data_rd) begin
            ptr_q <= ptr_q + 8'h01;
            if (ptr_q == LAST_WORD) begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_SPIN: begin
          cnt_q <= cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) begin
            standby <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Completion interrupt, set beats clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intrq <= 1'b0;
    end else if (ce) begin
      if (done_d) begin
        intrq <= 1'b1;
      end else if (stat_rd) begin
        intrq <= 1'b0;
      end
    end
  end

  // Standby timer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmr_val_q <= 8'h00;
      unit_q    <= 32'h0000_0000;
      units_q   <= 8'h00;
    end else if (ce) begin
      if (cmd_wr || state_q != ST_IDLE || standby) begin
        unit_q  <= 32'h0000_0000;
        units_q <= 8'h00;
      end else if (unit_q == 32'(STANDBY_UNIT_CYC - 1)) begin
        unit_q  <= 32'h0000_0000;
        units_q <= units_q + 8'h01;
      end else begin
        unit_q <= unit_q + 32'h0000_0001;
      end
      if (cmd_wr && !abort_d && (hwdata[7:0] == OPC_STBY_A || hwdata[7:0] == OPC_STBY_B)) begin
        tmr_val_q <= scnt_q;
      end
    end
  end

  // Sector buffer
  always_ff @(posedge clk) begin
    if (ce && data_wr) begin
      buf_mem[ptr_q] <= hwdata[15:0];
    end
  end

  // Read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && rd_take) begin
      if (haddr[7:0] == OFF_STAT) begin
        hrdata <= {24'h000000, (state_q == ST_BUSY || state_q == ST_STORE || state_q == ST_SPIN), 1'b1,
                   standby, 1'b0, (state_q == ST_DRQ_IN || state_q == ST_DRQ_OUT), 2'h0, err_q[ERR_ABRT_BIT]};
      end else if (haddr[7:0] == OFF_ERR) begin
        hrdata <= {24'h000000, err_q};
      end else if (data_rd) begin
        hrdata <= {16'h0000, buf_mem[ptr_q]};
      end else if (haddr[7:0] == OFF_FEAT) begin
        hrdata <= {24'h000000, feat_q};
      end else if (haddr[7:0] == OFF_SCNT) begin
        hrdata <= {24'h000000, scnt_q};
      end else if (haddr[7:0] == OFF_LBAL) begin
        hrdata <= {24'h000000, lbal_q};
      end else if (haddr[7:0] == OFF_LBAM) begin
        hrdata <= {24'h000000, lbam_q};
      end else if (haddr[7:0] == OFF_LBAH) begin
        hrdata <= {24'h000000, lbah_q};
      end else if (haddr[7:0] == OFF_DEVH) begin
        hrdata <= {24'h000000, devh_q};
      end else if (haddr[7:0] == OFF_CTRL) begin
        hrdata <= {24'h000000, ctrl_q};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // Checks
  a_save_busy_end: assert property (@(posedge clk) disable iff (rst)
    (ce && state_q == ST_BUSY && cnt_q == 16'h0001) |=> (state_q == ST_IDLE && intrq && nvm_req && !nvm_is_log))
    else $error("save did not end with intrq and store");
  a_save_start: assert property (@(posedge clk) disable iff (rst)
    (ce && cmd_wr && !abort_d && hwdata[7:0] == OPC_SMART && feat_q == SUB_SAVE) |=> (state_q == ST_BUSY && cnt_q == SAVE_CYC))
    else $error("save did not start busy");
  a_smart_abort: assert property (@(posedge clk) disable iff (rst)
    (ce && cmd_wr && hwdata[7:0] == OPC_SMART && !ctrl_q[CTRL_SMART_BIT]) |=> (err_q[ERR_ABRT_BIT] && intrq && state_q == ST_IDLE))
    else $error("disabled smart not aborted");
  a_log_ro_abort: assert property (@(posedge clk) disable iff (rst)
    (ce && cmd_wr && hwdata[7:0] == OPC_SMART && feat_q == SUB_WLOG && !log_writable(lbal_q)) |=> err_q[ERR_ABRT_BIT])
    else $error("read-only log not aborted");
  a_log_store: assert property (@(posedge clk) disable iff (rst)
    (ce && state_q == ST_STORE && cnt_q == 16'h0001) |=> (nvm_req && nvm_is_log && nvm_log_addr == lbal_q))
    else $error("log sector not stored to lbal");
  a_stby_enter: assert property (@(posedge clk) disable iff (rst)
    (ce && state_q == ST_SPIN && cnt_q == 16'h0001) |=> (standby && spin_down))
    else $error("standby not entered");
  a_stbyi_early: assert property (@(posedge clk) disable iff (rst)
    (ce && cmd_wr && !abort_d && (hwdata[7:0] == OPC_STBYI_A || hwdata[7:0] == OPC_STBYI_B))
    |=> (intrq && !standby && state_q == ST_SPIN))
    else $error("standby immediate interrupt late");
  a_timer_load: assert property (@(posedge clk) disable iff (rst)
    (ce && cmd_wr && !abort_d && (hwdata[7:0] == OPC_STBY_A || hwdata[7:0] == OPC_STBY_B))
    |=> (tmr_val_q == $past(scnt_q)))
    else $error("standby timer not loaded");
  a_wbuf_end: assert property (@(posedge clk) disable iff (rst)
    (ce && data_wr && ptr_q == LAST_WORD && op_q == OP_WBUF) |=> (state_q == ST_IDLE && intrq))
    else $error("write buffer did not complete");
endmodule

// File: dv/ata_host_model.sv
// Host model: AHB-Lite master that loads the task file and moves sectors
`timescale 1ns/1ps
module ata_host_model import ata_cmd_pkg::*; (
  input  wire logic        clk,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout,
  output logic             stuck
);
  logic [31:0] junk;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    stuck = 1'b0;
  end
  // Bounded wait for the slave's ready
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) stuck = 1'b1;
  endtask
  // Single word transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    hwdata <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, junk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic load_cmd(input logic [7:0] feat, scnt, lbal, lbam, lbah, devh, opc);
    wr(OFF_FEAT, {24'h0, feat});
    wr(OFF_SCNT, {24'h0, scnt});
    wr(OFF_LBAL, {24'h0, lbal});
    wr(OFF_LBAM, {24'h0, lbam});
    wr(OFF_LBAH, {24'h0, lbah});
    wr(OFF_DEVH, {24'h0, devh});
    wr(OFF_CMD, {24'h0, opc});
  endtask
  task automatic send_sector(input logic [15:0] seed);
    for (int i = 0; i < 256; i++) begin
      wr(OFF_DATA, {16'h0, seed ^ (16'(i) * 16'h0101)});
    end
  endtask
endmodule

// File: dv/ata_power_smart_buffer_cmds_tb.sv
// Self-checking bench for the task-file command engine
`timescale 1ns/1ps
module ata_power_smart_buffer_cmds_tb import ata_cmd_pkg::*;;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        hsel, hwrite, hreadyout, hresp, intrq, nvm_req, nvm_is_log, spin_down, standby, stuck, last_log;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  nvm_log_addr, last_addr, st;
  int          n_fail = 0;
  int          total_checks = 0;
  int          n_nvm = 0;
  int          n0;
  always #5 clk = ~clk;
  ata_host_model host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .stuck(stuck));
  ata_cmd_engine #(.STANDBY_UNIT_CYC(20)) dut (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .intrq(intrq), .nvm_req(nvm_req), .nvm_is_log(nvm_is_log),
    .nvm_log_addr(nvm_log_addr), .spin_down(spin_down), .standby(standby));
  always @(posedge clk) begin
    if (nvm_req === 1'b1) begin
      n_nvm <= n_nvm + 1;
      last_log <= nvm_is_log;
      last_addr <= nvm_log_addr;
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic give_up();
    n_fail++;
    report_and_stop();
  endtask
  // Bus wait ran out in the host
  always @(posedge stuck) give_up();
  task automatic wait_irq(input int lim, output logic [7:0] s);
    int n;
    n = 0;
    while (intrq !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > lim) give_up();
    end
    host.rd(OFF_STAT, rdv);
    s = rdv[7:0];
  endtask
  task automatic wait_drq();
    int n;
    n = 0;
    host.rd(OFF_STAT, rdv);
    while (rdv[STAT_DRQ_BIT] !== 1'b1) begin
      n++;
      if (n > 200) give_up();
      host.rd(OFF_STAT, rdv);
    end
  endtask
  task automatic wait_stby();
    int n;
    n = 0;
    while (standby !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 1000) give_up();
    end
  endtask
  task automatic t_save();
    n0 = n_nvm;
    host.load_cmd(SUB_SAVE, 8'h00, 8'h00, SMART_MID, SMART_HIGH, 8'h00, OPC_SMART);
    host.rd(OFF_STAT, rdv);
    chk("save busy", rdv[STAT_BSY_BIT], 1); // busy while saving
    ce <= 1'b0;
    repeat (300) @(posedge clk);
    chk("frozen save irq", intrq, 0); // no interrupt while frozen
    chk("frozen save store", n_nvm - n0, 0); // no store while frozen
    ce <= 1'b1;
    wait_irq(400, st);
    chk("save status", st, 8'h40); // busy dropped
    chk("save stores", n_nvm - n0, 1); // one store
    chk("save kind", last_log, 0); // attribute store
  endtask
  task automatic t_abort();
    logic [7:0] f [4] = '{SUB_SAVE, SUB_SAVE, 8'hd9, SUB_SAVE};
    logic [7:0] m [4] = '{8'h4e, SMART_MID, SMART_MID, SMART_MID};
    logic [7:0] h [4] = '{SMART_HIGH, 8'hc3, SMART_HIGH, SMART_HIGH};
    for (int i = 0; i < 4; i++) begin
      n0 = n_nvm;
      host.wr(OFF_CTRL, (i == 3) ? 32'h0 : {24'h0, CTRL_RST});
      host.load_cmd(f[i], 8'h00, 8'h00, m[i], h[i], 8'h00, OPC_SMART);
      wait_irq(400, st);
      chk("smart abort status", st, 8'h41); // aborted
      host.rd(OFF_ERR, rdv);
      chk("smart abort code", rdv[7:0], 8'h04); // abort code
      chk("smart abort stores", n_nvm - n0, 0); // nothing stored
    end
    host.wr(OFF_CTRL, {24'h0, CTRL_RST});
  endtask
  task automatic t_log();
    logic [7:0] la [4] = '{8'h7f, 8'ha0, LOG_WR_LO, LOG_WR_HI};
    int         ns [4] = '{1, 1, 2, 1};
    for (int i = 0; i < 4; i++) begin
      n0 = n_nvm;
      host.load_cmd(SUB_WLOG, 8'(ns[i]), la[i], SMART_MID, SMART_HIGH, 8'h00, OPC_SMART);
      if (i < 2) begin
        wait_irq(400, st);
        chk("ro log status", st, 8'h41); // read-only abort
        chk("ro log stores", n_nvm - n0, 0); // nothing stored
      end else begin
        for (int s = 0; s < ns[i]; s++) begin
          wait_drq();
          host.send_sector(16'h1200 + 16'(s));
          host.rd(OFF_STAT, rdv);
          chk("log sector busy", rdv[STAT_BSY_BIT], 1); // busy per sector
        end
        wait_irq(400, st);
        chk("log status", st, 8'h40); // clean completion
        chk("log stores", n_nvm - n0, ns[i]); // one store per sector
        chk("log kind", last_log, 1); // log store
        chk("log address", last_addr, la[i]); // address from low field
      end
    end
  endtask
  task automatic t_buf();
    host.load_cmd(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, OPC_WBUF);
    host.rd(OFF_STAT, rdv);
    chk("other drive", rdv[7:0], 8'h40); // drive select
    host.load_cmd(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, OPC_WBUF);
    wait_drq();
    host.send_sector(16'h5a00);
    wait_irq(400, st);
    chk("wbuf done", st, 8'h40); // sector taken
    host.load_cmd(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, OPC_RBUF);
    wait_drq();
    for (int i = 0; i < 256; i++) begin
      host.rd(OFF_DATA, rdv);
      chk("rbuf word", rdv[15:0], 16'h5a00 ^ (16'(i) * 16'h0101)); // same data back
    end
    wait_irq(400, st);
  endtask
  task automatic t_stby();
    logic [7:0] op [4] = '{OPC_STBY_A, OPC_STBY_B, OPC_STBYI_A, OPC_STBYI_B};
    for (int i = 0; i < 4; i++) begin
      host.load_cmd(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, op[i]);
      wait_irq(1000, st);
      if (i > 1) begin
        chk("early irq", standby, 0); // interrupt before standby
        chk("spinning", spin_down, 1); // spin down
        wait_stby();
        host.rd(OFF_STAT, rdv);
        st = rdv[7:0];
      end
      chk("standby reached", standby, 1); // standby mode
      chk("standby flag", st[STAT_STBY_BIT], 1); // status flag
    end
  endtask
  task automatic t_timer();
    host.load_cmd(8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, OPC_STBY_B);
    wait_irq(1000, st);
    host.load_cmd(SUB_SAVE, 8'h00, 8'h00, SMART_MID, SMART_HIGH, 8'h00, OPC_SMART);
    wait_irq(400, st);
    chk("woken", standby, 0); // awake before expiry
    wait_stby();
    chk("timer no irq", intrq, 0); // silent spin down
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    repeat (1000) @(posedge clk);
    chk("power-on standby", standby, 0); // timer off
    chk("power-on spin", spin_down, 0); // no timed spin down
    t_save();
    t_abort();
    t_log();
    t_buf();
    t_stby();
    t_timer();
    chk("bus stall", stuck, 0);
    chk("bus response", hresp, 0);
    chk("bus ready", hreadyout, 1);
    report_and_stop();
  end
endmodule
